// ==== rtl/instr_decode_defines.vh ====
// Purpose: constants for the instruction decode and timing block
// Assumes: 14-bit instruction words, four oscillator clocks per instruction cycle
// Notes:   definitions only
`ifndef INSTR_DECODE_DEFINES_VH
`define INSTR_DECODE_DEFINES_VH

// instruction word and fields
`define IW_WIDTH        14
`define FADDR_WIDTH     7
`define BITIDX_WIDTH    3
`define LIT8_WIDTH      8
`define LIT11_WIDTH     11
`define DATA_WIDTH      8
`define DEST_BIT        7
`define BITIDX_LSB      7
`define FADDR_MAX       7'h7f

// instruction classes
`define CLS_BYTE        2'h0
`define CLS_BIT         2'h1
`define CLS_LITCTL      2'h2

// timing: four oscillator clocks per instruction cycle
`define OSC_PER_ICYC    4
`define PHASE_WIDTH     2
`define PHASE_LAST      2'h3
`define PHASE_READ      2'h1
`define PHASE_WRITE     2'h3

// file register addresses of the two indirect access ports, pointer space split
`define INDIRECT_PORT0  7'h00
`define INDIRECT_PORT1  7'h01
`define PTR_PROG_BIT    15

`endif

// ==== rtl/instr_field_split.v ====
// Purpose: splits one 14-bit instruction word into class and operand fields
// Assumes: combinational, fed from the latched instruction register
// Notes:   every operand field is sliced from the word for every class, don't-care bits included; class is decoded
`include "instr_decode_defines.vh"

module instr_field_split (
    // instruction in
    input  wire [13:0] instrWord,
    // decoded fields
    output reg  [1:0]  instrClass,
    output wire [6:0]  fileAddr,
    output wire [2:0]  bitIndex,
    output wire        destSel,
    output wire [7:0]  literal8,
    output wire [10:0] literal11,
    output wire        ptrSel
);

    // class from the top two opcode bits
    always @*
    begin
        case (instrWord[13:12])
            2'h0:    instrClass = `CLS_BYTE;
            2'h1:    instrClass = `CLS_BIT;
            default: instrClass = `CLS_LITCTL;
        endcase
    end

    // operand fields; all taken from the one word, no extension words
    assign fileAddr  = instrWord[6:0];
    assign bitIndex  = instrWord[`BITIDX_LSB+2:`BITIDX_LSB];
    assign destSel   = instrWord[`DEST_BIT];
    assign literal8  = instrWord[7:0];
    assign literal11 = instrWord[10:0];
    assign ptrSel    = instrWord[0];

endmodule

// ==== rtl/instr_decode_timing.v ====
// Purpose: instruction decode, cycle timing and read-modify-write sequencing
// Assumes: program memory answers fetches combinationally; file memory read
//          data is valid in the phase after fileReadEn
// Notes:   ALU is outside; this block steers its result by destSel
//
// Functional notes
// - each instruction is one 14-bit word with all operands, no extensions
// - opcodes split into byte, bit, and literal/control classes
// - all other instructions finish in exactly one instruction cycle
// - absolute and computed subroutine invocations take two cycles
// - plain return, return with literal, interrupt exit take two cycles
// - jumps and taken skips take two cycles
// - indirect access with pointer in program memory adds one cycle
// - one instruction cycle is four oscillator clocks
// - file operands are always read, modified, then stored
// - destination bit 0 writes accumulator, 1 writes file register
// - file address field covers 0x00 to 0x7F
// - bit index selects one bit of the 8-bit register
// - pointer select field picks pointer pair 0 or 1
// - don't-care bits have no effect on execution
// - bit instructions carry a 3-bit index and 7-bit address
// - general literal instructions carry an 8-bit constant
// - jumps and invocations carry an 11-bit target
`include "instr_decode_defines.vh"

module instr_decode_timing (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // program memory
    input  wire [13:0] fetchWord,
    input  wire        fetchValid,
    output wire        fetchEn,
    // condition inputs from the datapath
    input  wire        skipTaken,
    input  wire [15:0] ptr0,
    input  wire [15:0] ptr1,
    // decoded fields
    output reg  [1:0]  instrClass,
    output reg  [6:0]  fileAddr,
    output reg  [2:0]  bitIndex,
    output reg  [7:0]  literal8,
    output reg  [10:0] literal11,
    output reg         ptrSel,
    // execution control
    output reg  [1:0]  phase,
    output reg         icycStrobe,
    output reg         fileReadEn,
    output reg         fileWriteEn,
    output reg         accWriteEn,
    output reg         flowChange,
    output reg         nopCycle,
    output reg         extraCycle
);

    localparam ST_EXEC  = 2'h0;
    localparam ST_FLUSH = 2'h1;
    localparam ST_XTRA  = 2'h2;

    reg  [1:0]  rstSync_reg;
    wire        rstInt_n;
    reg  [1:0]  phase_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [13:0] iw_reg;
    reg         xtraDone_reg;
    wire [1:0]  cls;
    wire [6:0]  fa;
    wire [2:0]  bi;
    wire        ds;
    wire [7:0]  k8;
    wire [10:0] k11;
    wire        ps;
    wire        endOfCyc;
    wire        isFlow;
    wire        isIndirect;
    wire        ptrInProg;
    wire        usesFile;

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstSync_reg <= 2'h0;
        else
            rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
    assign rstInt_n = rstSync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // field split of the current instruction
    instr_field_split u_split (
        .instrWord  (iw_reg),
        .instrClass (cls),
        .fileAddr   (fa),
        .bitIndex   (bi),
        .destSel    (ds),
        .literal8   (k8),
        .literal11  (k11),
        .ptrSel     (ps)
    );

    // opcode group tests; calls and jumps share top bits 10, returns and
    // computed flow are fixed control encodings, bit skips are bit class 1x, decrement and increment skips are byte class
    function is_two_cycle;
        input [13:0] w;
        input        skip;
        begin
            is_two_cycle =
                (w[13:12] == 2'h2) ||
                (w[13:9] == 5'h19) ||                     // relative_jump
                (w == 14'h000a) || (w == 14'h000b) ||     // computed
                (w == 14'h0008) || (w == 14'h0009) ||     // returns
                (w[13:10] == 4'hd) ||                     // literal exit
                ((w[13:11] == 3'h3) && skip) ||           // bit skips
                ((w[13:8] == 6'h0b) && skip) ||           // decrement skip
                ((w[13:8] == 6'h0f) && skip);             // increment skip
        end
    endfunction

    // the gap left by an out-of-range address is impossible: seven bits
    // control forms with a zero upper field name no file register at all
    assign usesFile   = (cls != `CLS_LITCTL) && (iw_reg[13:7] != 7'h00);
    assign isIndirect = usesFile &&
                        ((fa == `INDIRECT_PORT0) || (fa == `INDIRECT_PORT1));
    assign ptrInProg  = (fa == `INDIRECT_PORT1) ? ptr1[`PTR_PROG_BIT]
                                                 : ptr0[`PTR_PROG_BIT];
    assign isFlow     = is_two_cycle(iw_reg, skipTaken);
    assign endOfCyc   = (phase_reg == `PHASE_LAST);
    assign fetchEn    = endOfCyc && (state_next == ST_EXEC);

    ////////////////////////////////////////////////////////////////////////
    // four-clock phase counter gives the instruction cycle
    always @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
            phase_reg <= 2'h0;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    // sequencer next state, decided only at cycle end
    always @*
    begin
        state_next = state_reg;
        if (endOfCyc)
        begin
            case (state_reg)
                ST_EXEC:
                    if (isIndirect && ptrInProg && !xtraDone_reg)
                        state_next = ST_XTRA;
                    else if (isFlow)
                        state_next = ST_FLUSH;
                    else
                        state_next = ST_EXEC;
                ST_XTRA:  state_next = isFlow ? ST_FLUSH : ST_EXEC;
                default:  state_next = ST_EXEC;
            endcase
        end
    end

    // instruction register and sequencer; flush cycle discards prefetch
    always @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            state_reg    <= ST_FLUSH;
            iw_reg       <= 14'h0000;
            xtraDone_reg <= 1'b0;
        end
        else if (endOfCyc)
        begin
            state_reg    <= state_next;
            xtraDone_reg <= (state_next == ST_XTRA);
            if (state_next == ST_EXEC)
                iw_reg <= fetchValid ? fetchWord : 14'h0000;
            else if (state_next == ST_FLUSH)
                iw_reg <= 14'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs; read in phase 1, store in phase 3
    always @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            instrClass  <= `CLS_LITCTL;
            fileAddr    <= 7'h00;
            bitIndex    <= 3'h0;
            literal8    <= 8'h00;
            literal11   <= 11'h000;
            ptrSel      <= 1'b0;
            phase       <= 2'h0;
            icycStrobe  <= 1'b0;
            fileReadEn  <= 1'b0;
            fileWriteEn <= 1'b0;
            accWriteEn  <= 1'b0;
            flowChange  <= 1'b0;
            nopCycle    <= 1'b1;
            extraCycle  <= 1'b0;
        end
        else
        begin
            instrClass  <= cls;
            fileAddr    <= fa;
            bitIndex    <= bi;
            literal8    <= k8;
            literal11   <= k11;
            ptrSel      <= ps;
            phase       <= phase_reg;
            icycStrobe  <= endOfCyc;
            // read happens even for write-only forms
            fileReadEn  <= (state_reg == ST_EXEC) && usesFile &&
                           (phase_reg == `PHASE_READ);
            fileWriteEn <= (state_reg == ST_EXEC) && usesFile &&
                           (phase_reg == `PHASE_WRITE) &&
                           (cls == `CLS_BIT || ds);
            accWriteEn  <= (state_reg == ST_EXEC) && (cls == `CLS_BYTE) && usesFile &&
                           (phase_reg == `PHASE_WRITE) && !ds;
            // marks the cycle end that enters the flush, also after an extra cycle
            flowChange  <= endOfCyc && (state_next == ST_FLUSH);
            nopCycle    <= (state_next == ST_FLUSH) || (state_reg == ST_FLUSH);
            extraCycle  <= (state_reg == ST_XTRA);
        end
    end

endmodule

// ==== tb/prog_mem_model.sv ====
// Purpose: program memory partner answering instruction fetches
// Assumes: words are answered combinationally while fetchEn is high
// Notes:   outside a fetch the bus carries the inverse word
module prog_mem_model (
    // fetch request
    input  wire logic        fetchEn,
    input  wire logic [13:0] nextWord,
    // word to the core
    output logic      [13:0] fetchWord,
    output logic             fetchValid
);
timeunit 1ns;
timeprecision 1ns;
// whole word each fetch, never an extension word
assign fetchValid = 1'b1;
// inverse when idle so a late sample cannot pass by luck
assign fetchWord = fetchEn ? nextWord : ~nextWord;
endmodule

// ==== tb/instr_decode_timing_checker.sv ====
// Purpose: port timing checks for the decode block
// Assumes: phase output lags the internal phase counter by one clock
// Notes:   bound to every instance of the decode block
`include "instr_decode_defines.vh"
module instr_decode_timing_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       fetchEn,
    input wire logic [1:0] instrClass,
    input wire logic [6:0] fileAddr,
    input wire logic [1:0] phase,
    input wire logic       icycStrobe,
    input wire logic       fileReadEn,
    input wire logic       fileWriteEn,
    input wire logic       accWriteEn,
    input wire logic       flowChange,
    input wire logic       nopCycle
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
chk_strobe_period: assert property (icycStrobe |-> ##4 icycStrobe)
    else $error("strobe period wrong");
chk_strobe_gap: assert property (icycStrobe |=> !icycStrobe [*3])
    else $error("strobe too early");
chk_fetch_phase: assert property (fetchEn |-> phase == 2'h2)
    else $error("fetch outside last phase");
chk_read_before: assert property (fileWriteEn |-> $past(fileReadEn, 2))
    else $error("store without read");
chk_dest_onehot: assert property (!(fileWriteEn && accWriteEn))
    else $error("two destinations");
chk_acc_byte: assert property (accWriteEn |-> instrClass == `CLS_BYTE)
    else $error("acc write outside byte class");
chk_lit_noread: assert property (fileReadEn |-> instrClass != `CLS_LITCTL)
    else $error("literal class read file");
chk_flush_after: assert property (flowChange |=> nopCycle)
    else $error("no flush after flow change");
chk_field_hold: assert property ($changed(fileAddr) |=> $stable(fileAddr) [*3])
    else $error("fields not held");
endmodule
bind instr_decode_timing instr_decode_timing_checker chk (.clk(clk), .rst_n(rst_n),
    .fetchEn(fetchEn), .instrClass(instrClass), .fileAddr(fileAddr), .phase(phase),
    .icycStrobe(icycStrobe), .fileReadEn(fileReadEn), .fileWriteEn(fileWriteEn),
    .accWriteEn(accWriteEn), .flowChange(flowChange), .nopCycle(nopCycle));

// ==== tb/cpu_instruction_decode_timing_bench.sv ====
// Purpose: self-checking bench for decode fields and cycle counts
// Assumes: 14'h3000 is a one-cycle literal filler with no register access
// Notes:   each word is followed by a filler so its late store is seen
module cpu_instruction_decode_timing_bench;
timeunit 1ns;
timeprecision 1ns;
logic        clk = 0, rst_n = 0, skipTaken = 0, fetchEn, fetchValid, ptrSel;
logic        icycStrobe, fileReadEn, fileWriteEn, accWriteEn, extraCycle;
logic [15:0] ptr0 = 0, ptr1 = 0, seed = 16'h25cf;
logic [13:0] nextWord = 14'h3000, fetchWord;
logic [1:0]  instrClass, phase;
logic [6:0]  fileAddr;
logic [2:0]  bitIndex;
logic [7:0]  literal8;
logic [10:0] literal11;
logic [16:0] e;
int          n_errors = 0, samples_checked = 0;
// {pointer0 in program, pointer1 in program, skip, word}
logic [16:0] tbl [0:15] = '{17'h02005, 17'h0000a, 17'h00008, 17'h00009, 17'h03405,
    17'h02805, 17'h03205, 17'h0000b, 17'h05c85, 17'h01c85, 17'h04b85, 17'h04f85,
    17'h10780, 17'h08781, 17'h11400, 17'h14b80};
////////////////////////////////////////////////////////////////////////////////
initial
    forever #5 clk = ~clk;
instr_decode_timing dut (.clk(clk), .rst_n(rst_n), .fetchWord(fetchWord),
    .fetchValid(fetchValid), .fetchEn(fetchEn), .skipTaken(skipTaken), .ptr0(ptr0),
    .ptr1(ptr1), .instrClass(instrClass), .fileAddr(fileAddr), .bitIndex(bitIndex),
    .literal8(literal8), .literal11(literal11), .ptrSel(ptrSel), .phase(phase),
    .icycStrobe(icycStrobe), .fileReadEn(fileReadEn), .fileWriteEn(fileWriteEn),
    .accWriteEn(accWriteEn), .flowChange(), .nopCycle(), .extraCycle(extraCycle));
prog_mem_model pm (.fetchEn(fetchEn), .nextWord(nextWord), .fetchWord(fetchWord),
    .fetchValid(fetchValid));
////////////////////////////////////////////////////////////////////////////////
function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
endfunction
// clocks per instruction: flow changes double, program pointer adds a cycle
function automatic int exp_cyc(input logic [16:0] v);
    int c;
    logic [13:0] w;
    w = v[13:0];
    c = 1;
    if (w[13:12] == 2'h2 || w[13:9] == 5'h19 || w[13:10] == 4'hd || w[13:2] == 12'h002)
        c = 2;
    if (v[14] && (w[13:11] == 3'h3 || w[13:8] == 6'h0b || w[13:8] == 6'h0f))
        c = 2;
    if (!w[13] && w[13:7] != 0 && (w[6:0] == 0 && v[16] || w[6:0] == 1 && v[15]))
        c++;
    return 4 * c;
endfunction
task cmp(input logic [10:0] got, input logic [10:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
        n_errors++;
        $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
    end
endtask
task final_report;
    if (n_errors == 0 && samples_checked > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
// present one word, time it from its fetch edge to the next fetch edge
task issue(input logic [16:0] v);
    logic [13:0] w;
    logic ind;
    int n, nr, na, nf, nx;
    w = v[13:0];
    n = 0;
    nr = 0;
    na = 0;
    nf = 0;
    nx = 0;
    ind = !w[13] && w[13:7] != 0 && (w[6:0] == 0 && v[16] || w[6:0] == 1 && v[15]);
    @(posedge clk);
    nextWord <= w;
    skipTaken <= v[14];
    ptr0 <= {v[16], seed[14:0]};
    ptr1 <= {v[15], seed[15:1]};
    do
        @(negedge clk);
    while (fetchEn !== 1'b1 && n++ < 100);
    if (n > 100)
    begin
        n_errors++;
        final_report;
    end
    @(posedge clk);
    nextWord <= 14'h3000;
    n = 0;
    do
    begin
        @(negedge clk);
        n++;
        nr += fileReadEn;
        na += accWriteEn;
        nf += fileWriteEn;
        nx += extraCycle;
        if (n == 2)
        begin
            cmp(instrClass, {w[13], !w[13] && w[12]}, "class");
            cmp(fileAddr, w[6:0], "addr");
            cmp(bitIndex, w[9:7], "bit");
            cmp(literal8, w[7:0], "lit8");
            cmp(literal11, w[10:0], "lit11");
            cmp(ptrSel, w[0], "ptr");
        end
    end
    while (fetchEn !== 1'b1 && n < 20);
    @(negedge clk);
    na += accWriteEn;
    nf += fileWriteEn;
    nx += extraCycle;
    cmp(n, exp_cyc(v), "length");
    cmp(nx, {ind, 2'h0}, "extra");
    cmp(nr, !w[13] && w[13:7] != 0, "reads");
    cmp(na, w[13:12] == 0 && !w[7] && w[13:7] != 0, "acc");
    cmp(nf, !w[13] && (w[12] || w[7]), "file");
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (tbl[i]) issue(tbl[i]);
    repeat (40)
    begin
        seed = lfsr(seed);
        e = {seed[15:13], seed[13:0]};
        if (e[13:7] == 0)
            e[12] = 1'b1;
        issue(e);
    end
    final_report;
end
endmodule
